// ==== host_model.sv ====
// Purpose: bus host stand-in issuing zero, tare and setup link
// Assumes: bench requests change just after a clock edge
// Notes: commands and link leave as the request levels, one cycle late
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Requests from the bench
  input wire logic zero_req,
  input wire logic tare_req,
  input wire logic link_req,
  // Lines to the device
  output logic zero_cmd,
  output logic tare_cmd,
  output logic setup_active
);
  logic [2:0] out_reg;
  logic [2:0] out_next;
  always_comb
  begin
    out_next = rst_n ? {link_req, tare_req, zero_req} : 3'h0;
  end
  // Registered, so lines change only after an edge
  always_ff @(posedge clock)
  begin
    out_reg <= out_next;
  end
  assign {setup_active, tare_cmd, zero_cmd} = out_reg;
endmodule
`default_nettype wire

// ==== settle_filter.sv ====
// Purpose: decimating and smoothing filter for raw load cell samples
// Assumes: one input sample per 1/1600 s, strobed by in_valid
// Notes: a change of setting takes effect at once, on the block under way
`timescale 1ns/1ps
`default_nettype none
module settle_filter
#(
  parameter int W = 24
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Setting
  input wire logic [3:0] setting,
  // Sample in
  input wire logic in_valid,
  input wire logic signed [W-1:0] in_data,
  // Value out
  output logic out_valid,
  output logic signed [W-1:0] out_data
);

  logic [4:0] cnt_reg, cnt_next;
  logic signed [W+5:0] sum_reg, sum_next;
  logic signed [W-1:0] y_reg, y_next;
  logic valid_reg, valid_next;
  logic signed [W+5:0] total;
  logic signed [W-1:0] avg;
  logic [4:0] last;

  // Block average, then first order smoothing
  always_comb
  begin
    cnt_next = cnt_reg;
    sum_next = sum_reg;
    y_next = y_reg;
    valid_next = 1'b0;
    last = 5'((6'h01 << weigh_pkg::decim_log2(setting)) - 6'h01);
    total = sum_reg + (W+6)'(in_data);
    avg = W'(total >>> weigh_pkg::decim_log2(setting));
    if (in_valid)
    begin
      if (cnt_reg >= last)
      begin
        cnt_next = 5'h00;
        sum_next = '0;
        y_next = y_reg + W'((avg - y_reg) >>> weigh_pkg::smooth_shift(setting));
        valid_next = 1'b1;
      end
      else
      begin
        cnt_next = cnt_reg + 5'h01;
        sum_next = total;
      end
    end
  end

  // Registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 5'h00;
      sum_reg <= '0;
      y_reg <= '0;
      valid_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      sum_reg <= sum_next;
      y_reg <= y_next;
      valid_reg <= valid_next;
    end
  end

  assign out_valid = valid_reg;
  assign out_data = y_reg;

endmodule
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench of the weighing value processor
// Assumes: 50 MHz clock, reset low for ten cycles
// Notes: count mode first, then weigh mode taring
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic SAMPLE_VALID = 1'b0;
  logic [3:0] REG_ADDR = 4'h0;
  logic [31:0] REG_WDATA = 32'h0;
  logic signed [23:0] SAMPLE_DATA = 24'sh0;
  logic signed [23:0] STORED_TARE = 24'sh0;
  logic zero_req = 1'b0;
  logic tare_req = 1'b0;
  logic link_req = 1'b0;
  logic ZERO_CMD, TARE_CMD, SETUP_ACTIVE, VALUE_VALID, STABLE, NET_MODE, CHECKSUM_ON;
  logic CR_ON, LF_ON, ADDR_IN_FRAME;
  logic [31:0] REG_RDATA;
  logic signed [31:0] VALUE_DATA;
  logic signed [23:0] TARE_TO_STORE;
  logic [1:0] PORT_FORMAT, FRAMING;
  logic [15:0] BAUD_DIVISOR;
  logic [4:0] SLAVE_ADDR;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_val = 0;
  int rates [7] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600};
  always #10 CLOCK = ~CLOCK;
  weighing_value_processor weighing_value_processor_inst (.*);
  host_model host_model_inst (.clock(CLOCK), .rst_n(RST_N), .zero_req(zero_req),
    .tare_req(tare_req), .link_req(link_req), .zero_cmd(ZERO_CMD), .tare_cmd(TARE_CMD),
    .setup_active(SETUP_ACTIVE));
  // Counts filtered values delivered
  always @(posedge CLOCK) n_val <= n_val + ((VALUE_VALID === 1'b1) ? 1 : 0);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Write, then two edges so port outputs follow
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
    repeat (2) @(posedge CLOCK);
    #1;
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] exp);
    @(posedge CLOCK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1;
    chk(REG_RDATA, exp);
  endtask
  task automatic send(input int n, input logic signed [23:0] v);
    repeat (n)
    begin
      @(posedge CLOCK);
      SAMPLE_VALID <= 1'b1;
      SAMPLE_DATA <= v;
      @(posedge CLOCK);
      SAMPLE_VALID <= 1'b0;
    end
    repeat (3) @(posedge CLOCK);
    #1;
  endtask
  task automatic cmd(input logic z);
    @(posedge CLOCK);
    zero_req <= z;
    tare_req <= !z;
    @(posedge CLOCK);
    zero_req <= 1'b0;
    tare_req <= 1'b0;
    repeat (3) @(posedge CLOCK);
    #1;
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge CLOCK);
    n_mismatch++;
    tally_and_finish;
  end
  initial
  begin
    repeat (10) @(posedge CLOCK);
    RST_N <= 1'b1;
    // Defaults, then an unmapped place
    rc(weigh_pkg::IDX_SCALE_CFG, 32'h0003_1138);
    rc(weigh_pkg::IDX_PORT_CFG, 32'h0000_047D);
    chk({CHECKSUM_ON, CR_ON, LF_ON, FRAMING}, 5'h1C);
    wr_reg(4'hF, 32'hFFFF_FFFF);
    rc(4'hF, 32'h0);
    // Every rate, framing and a spread of addresses
    for (int b = 0; b < 7; b++)
    begin
      wr_reg(weigh_pkg::IDX_PORT_CFG, {17'h0, 5'(b), 2'(b % 3), 3'(b), b[1], b[0], 3'h5});
      chk(BAUD_DIVISOR, 16'(weigh_pkg::CLK_HZ / (weigh_pkg::OVERSAMPLE * rates[b])));
      chk({PORT_FORMAT, FRAMING, SLAVE_ADDR, ADDR_IN_FRAME, CR_ON, LF_ON},
        {2'h1, 2'(b % 3), 5'(b), b != 0, b[0], b[1]});
    end
    // Modbus with odd framing and address zero asked for
    wr_reg(weigh_pkg::IDX_PORT_CFG, 32'h0000_017A);
    chk({PORT_FORMAT, FRAMING, SLAVE_ADDR}, 9'h101);
    link_req <= 1'b1;
    repeat (4) @(posedge CLOCK);
    chk(PORT_FORMAT, weigh_pkg::FMT_SETUP);
    link_req <= 1'b0;
    repeat (4) @(posedge CLOCK);
    chk(PORT_FORMAT, weigh_pkg::FMT_MODBUS);
    // Count mode, fastest filter, motion off; first value is swallowed
    wr_reg(weigh_pkg::IDX_SCALE_CFG, 32'h0003_1000);
    wr_reg(weigh_pkg::IDX_CAPACITY, 32'h0000_03E8);
    send(32, 24'sh00000A);
    chk(n_val, 31);
    send(1, 24'sh00000A);
    chk({n_val == 32, VALUE_DATA[29:0], STABLE}, {1'b1, 30'hA, 1'b1});
    cmd(1'b1);
    rc(weigh_pkg::IDX_GROSS, 32'h0);
    send(1, 24'sh000032);
    cmd(1'b1);
    rc(weigh_pkg::IDX_GROSS, 32'h28);
    cmd(1'b0);
    chk(NET_MODE, 1'b0);
    wr_reg(weigh_pkg::IDX_SCALE_CFG, 32'h0003_1008);
    send(8, 24'sh000032);
    chk(n_val, 37);
    // Half gain, then ten times finer, then count mode ignores it
    wr_reg(weigh_pkg::IDX_GAIN, 32'h0000_8000);
    wr_reg(weigh_pkg::IDX_SCALE_CFG, 32'h0003_1001);
    send(1, 24'sh000032);
    chk(VALUE_DATA, 32'h14);
    wr_reg(weigh_pkg::IDX_SCALE_CFG, 32'h0003_1005);
    send(1, 24'sh000032);
    chk(VALUE_DATA, 32'hC8);
    wr_reg(weigh_pkg::IDX_SCALE_CFG, 32'h0003_107C);
    send(1, 24'sh000032);
    chk(VALUE_DATA, 32'h32);
    // Tare refused while moving and while disabled, then taken
    wr_reg(weigh_pkg::IDX_SCALE_CFG, 32'h0003_1081);
    send(1, 24'sh00005A);
    cmd(1'b0);
    chk({STABLE, NET_MODE}, 2'h0);
    wr_reg(weigh_pkg::IDX_SCALE_CFG, 32'h0002_1001);
    send(1, 24'sh00005A);
    cmd(1'b0);
    chk({STABLE, NET_MODE}, 2'h2);
    wr_reg(weigh_pkg::IDX_SCALE_CFG, 32'h0003_1001);
    cmd(1'b0);
    chk({NET_MODE, TARE_TO_STORE}, {1'b1, 24'h50});
    rc(weigh_pkg::IDX_TARE, 32'h50);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ==== weigh_monitor.sv ====
// Purpose: port checks of the weighing value processor
// Assumes: one clock, synchronous active-low reset
// Notes: port outputs carry the setup from the first edge after reset
`timescale 1ns/1ps
`default_nettype none
module weigh_monitor
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Watched ports
  input wire logic REG_RD,
  input wire logic [weigh_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic TARE_CMD,
  input wire logic STABLE,
  input wire logic NET_MODE,
  input wire logic SETUP_ACTIVE,
  input wire logic [1:0] PORT_FORMAT,
  input wire logic [1:0] FRAMING,
  input wire logic [4:0] SLAVE_ADDR,
  input wire logic ADDR_IN_FRAME,
  input wire logic [15:0] BAUD_DIVISOR
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Two clean edges, so outputs no longer show reset zeros
  sequence s_settled; $past(RST_N) && $past(RST_N, 2); endsequence
  sequence s_link_held; SETUP_ACTIVE [*2]; endsequence
  sequence s_tare_moving; TARE_CMD && !STABLE && !NET_MODE; endsequence
  // Tare and link handling
  property p_tare_refused; s_tare_moving |=> !NET_MODE; endproperty
  a_tare_refused: assert property (p_tare_refused)
    else $error("tare taken while moving");
  property p_link_shown; s_link_held |=> PORT_FORMAT == weigh_pkg::FMT_SETUP; endproperty
  a_link_shown: assert property (p_link_shown)
    else $error("setup link not shown");
  property p_link_over; $fell(SETUP_ACTIVE) |-> ##2 PORT_FORMAT != weigh_pkg::FMT_SETUP; endproperty
  a_link_over: assert property (p_link_over)
    else $error("saved format not resumed");
  // Read data stands only after a read
  property p_read_idle; !REG_RD |=> REG_RDATA == '0; endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data without read");
  // Port setup relations
  property p_modbus_frame; PORT_FORMAT == weigh_pkg::FMT_MODBUS |-> FRAMING == 2'h0; endproperty
  a_modbus_frame: assert property (p_modbus_frame)
    else $error("modbus framing not 8N1");
  property p_modbus_addr; PORT_FORMAT == weigh_pkg::FMT_MODBUS |-> SLAVE_ADDR != 5'h00; endproperty
  a_modbus_addr: assert property (p_modbus_addr)
    else $error("modbus address zero");
  property p_addr_frame; ADDR_IN_FRAME == (SLAVE_ADDR != 5'h00); endproperty
  a_addr_frame: assert property (p_addr_frame)
    else $error("address flag wrong");
  property p_baud_legal;
    s_settled |-> BAUD_DIVISOR inside {16'h0A2C, 16'h0516, 16'h028B, 16'h0145,
      16'h00A2, 16'h0051, 16'h0036};
  endproperty
  a_baud_legal: assert property (p_baud_legal)
    else $error("baud divisor not a listed rate");
endmodule
bind weighing_value_processor weigh_monitor weigh_monitor_inst (.*);
`default_nettype wire

// ==== weigh_pkg.sv ====
// Purpose: shared constants and types of the weighing value processor
// Assumes: 50 MHz system clock, 24-bit filtered load cell samples
// Notes: register offsets are word indices; byte address is four times
`default_nettype none
package weigh_pkg;

  // ***************************************************
  // Widths and register map
  // ***************************************************
  localparam int SAMPLE_W = 24;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] IDX_SCALE_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_PORT_CFG = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_CAL_ZERO = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_CAPACITY = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_INTERVAL = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_GAIN = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_GROSS = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_TARE = 4'h8;

  // ***************************************************
  // Modes, formats and fixed factors
  // ***************************************************
  localparam logic [1:0] MODE_COUNT = 2'h0;
  localparam logic [1:0] FMT_OFF = 2'h0;
  localparam logic [1:0] FMT_LEGACY = 2'h1;
  localparam logic [1:0] FMT_MODBUS = 2'h2;
  localparam logic [1:0] FMT_SETUP = 2'h3;
  localparam logic [1:0] FRAME_8N1 = 2'h0;
  localparam logic [4:0] ADDR_MIN = 5'h01;
  localparam int HIRES_FACTOR = 10;
  localparam int GAIN_SHIFT = 16;
  localparam int PERCENT = 100;
  localparam int TENTHS = 10;
  localparam int CLK_HZ = 50000000;
  localparam int OVERSAMPLE = 16;

  // ***************************************************
  // Configuration carriers
  // ***************************************************
  typedef struct packed {
    logic save_tare;
    logic tare_en;
    logic [1:0] auto_zero_follow;
    logic [1:0] zero_range;
    logic [1:0] power_zero;
    logic [2:0] motion;
    logic [3:0] filter;
    logic hi_res;
    logic [1:0] mode;
  } scale_cfg_type;

  typedef struct packed {
    logic [4:0] address;
    logic [1:0] framing;
    logic [2:0] baud;
    logic lf_en;
    logic cr_en;
    logic checksum_en;
    logic [1:0] format;
  } port_cfg_type;

  localparam scale_cfg_type SCALE_CFG_RST = '{save_tare: 1'b1, tare_en: 1'b1,
    auto_zero_follow: 2'h0, zero_range: 2'h1, power_zero: 2'h0, motion: 3'h2,
    filter: 4'h7, hi_res: 1'b0, mode: MODE_COUNT};
  localparam port_cfg_type PORT_CFG_RST = '{address: 5'h01, framing: FRAME_8N1,
    baud: 3'h3, lf_en: 1'b1, cr_en: 1'b1, checksum_en: 1'b1, format: FMT_LEGACY};

  // Decimation (log2) per filter setting, from a 1600 per second input
  function automatic logic [2:0] decim_log2(input logic [3:0] s);
    case (s)
      4'h0: decim_log2 = 3'h0;
      4'h1: decim_log2 = 3'h1;
      4'h2: decim_log2 = 3'h2;
      4'h3: decim_log2 = 3'h3;
      4'h4, 4'h5, 4'h6: decim_log2 = 3'h4;
      default: decim_log2 = 3'h5;
    endcase
  endfunction

  // Smoothing shift; slower settings at one rate differ here
  function automatic logic [1:0] smooth_shift(input logic [3:0] s);
    case (s)
      4'h5, 4'h8: smooth_shift = 2'h1;
      4'h6: smooth_shift = 2'h2;
      4'h9: smooth_shift = 2'h3;
      default: smooth_shift = 2'h0;
    endcase
  endfunction

  // Oversampled bit divisor per baud selection
  function automatic logic [15:0] baud_div(input logic [2:0] b);
    int rate;
    case (b)
      3'h0: rate = 1200;
      3'h1: rate = 2400;
      3'h2: rate = 4800;
      3'h4: rate = 19200;
      3'h5: rate = 38400;
      3'h6: rate = 57600;
      default: rate = 9600;
    endcase
    baud_div = 16'(CLK_HZ / (OVERSAMPLE * rate));
  endfunction

endpackage
`default_nettype wire

// ==== weighing_value_processor.sv ====
// Purpose: turns filtered load cell samples into count, weight or force
// Assumes: samples synchronous to CLOCK; nonvolatile store is outside
// Notes: registers on a plain strobe port, read data one cycle later
// Operation
// - Increased resolution gives ten times finer output in weigh/force mode only, off by default.
// - The filter setting runs 0 to 9, default 7, with the printed output rates.
// - The motion window is off, 0.3e, 0.5e, 1e or 2e, or off, 60, 100, 200, 400 counts in count mode.
// - Power-on zeroing at 2% or 10% acts only if drift from calibrated zero is inside the window.
// - A zero command acts only when stable and inside the 2%, 20% or 40% zeroing range.
// - Zero tracking of 0.5e, 1e or 3e acts only inside the zeroing range, never in count mode.
// - A tare command tares only with tare enabled, positive gross and no motion, repeatedly.
// - With save-tare on in weigh/force mode, the tare survives power off and start-up is in net mode.
// - Port format is off, legacy ASCII or Modbus RTU, default set by the variant.
// - A setup link is served in any format, then the saved format resumes.
// - The checksum is used in legacy ASCII format only when enabled.
// - Carriage return and line feed are each switchable, both on by default.
// - Baud rate is 1200 to 57600, default 9600, the same at both ends.
// - Framing is 8N1 by default, or 7 data bits with odd or even parity.
// - Slave address runs 1 to 31, default 1, and 0 means no address in frames.
// - Modbus RTU forces 8N1 framing and an address from 1 to 31.
`timescale 1ns/1ps
`default_nettype none
module weighing_value_processor
#(
  parameter int W = 24,
  parameter bit MODBUS_VARIANT = 1'b0
)
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register port
  input wire logic [weigh_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [weigh_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [weigh_pkg::DATA_W-1:0] REG_RDATA,
  // Sample stream
  input wire logic SAMPLE_VALID,
  input wire logic signed [W-1:0] SAMPLE_DATA,
  // Host commands
  input wire logic ZERO_CMD,
  input wire logic TARE_CMD,
  input wire logic SETUP_ACTIVE,
  // Stored tare
  input wire logic signed [W-1:0] STORED_TARE,
  output logic signed [W-1:0] TARE_TO_STORE,
  // Values
  output logic VALUE_VALID,
  output logic signed [weigh_pkg::DATA_W-1:0] VALUE_DATA,
  output logic STABLE,
  output logic NET_MODE,
  // Serial port setup
  output logic [1:0] PORT_FORMAT,
  output logic CHECKSUM_ON,
  output logic CR_ON,
  output logic LF_ON,
  output logic [15:0] BAUD_DIVISOR,
  output logic [1:0] FRAMING,
  output logic [4:0] SLAVE_ADDR,
  output logic ADDR_IN_FRAME
);

  // ***************************************************
  // Decoding helpers
  // ***************************************************

  function automatic logic [W:0] mag(input logic signed [W:0] d);
    mag = d[W] ? -d : d;
  endfunction

  // Deviation inside a percentage of capacity
  function automatic logic in_pct(input logic signed [W:0] d,
                                  input logic [W-1:0] cap,
                                  input logic [5:0] pct);
    in_pct = (48'(mag(d)) * 48'(weigh_pkg::PERCENT)) <= (48'(cap) * 48'(pct));
  endfunction

  // Deviation inside a window given in tenths of an interval
  function automatic logic in_e(input logic signed [W:0] d,
                                input logic [W-1:0] intv,
                                input logic [4:0] tenths);
    in_e = (48'(mag(d)) * 48'(weigh_pkg::TENTHS)) <= (48'(intv) * 48'(tenths));
  endfunction

  // ***************************************************
  // State
  // ***************************************************
  typedef enum {ST_POWER_UP, ST_RUN} phase_type;

  weigh_pkg::scale_cfg_type cfg_reg, cfg_next;
  weigh_pkg::port_cfg_type port_reg, port_next;
  logic signed [W-1:0] cal_zero_reg, cal_zero_next;
  logic [W-1:0] cap_reg, cap_next, intv_reg, intv_next;
  logic [15:0] gain_reg, gain_next;
  logic [weigh_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  phase_type phase_reg, phase_next;
  logic signed [W-1:0] prev_reg, prev_next, cur_reg, cur_next;
  logic signed [W-1:0] zero_reg, zero_next, tare_reg, tare_next;
  logic stable_reg, stable_next, net_reg, net_next, pz_hit_reg, pz_hit_next;
  logic vvalid_reg, vvalid_next;
  logic signed [weigh_pkg::DATA_W-1:0] value_reg, value_next;
  logic [1:0] fmt_reg, fmt_next, frame_reg, frame_next;
  logic cks_reg, cks_next, cr_reg, cr_next, lf_reg, lf_next, aen_reg, aen_next;
  logic [15:0] div_reg, div_next;
  logic [4:0] addr_reg, addr_next;

  logic f_valid;
  logic signed [W-1:0] f_data;
  logic count_mode;
  logic signed [W:0] gross, drift, step, shown;
  logic signed [47:0] scaled;
  logic [5:0] zr_pct, pz_pct;
  logic [8:0] mcount;
  logic [4:0] mtenths, atenths;
  logic motion_ok, range_ok;

  // ***************************************************
  // Filter stage
  // ***************************************************

  settle_filter #(.W(W)) filter_inst
  (
    .clock(CLOCK),
    .rst_n(RST_N),
    .setting(cfg_reg.filter),
    .in_valid(SAMPLE_VALID),
    .in_data(SAMPLE_DATA),
    .out_valid(f_valid),
    .out_data(f_data)
  );

  // ***************************************************
  // Register port
  // ***************************************************

  // Writes and read data; unmapped reads give zero
  always_comb
  begin
    cfg_next = cfg_reg;
    port_next = port_reg;
    cal_zero_next = cal_zero_reg;
    cap_next = cap_reg;
    intv_next = intv_reg;
    gain_next = gain_reg;
    rdata_next = '0;
    if (REG_WR)
    begin
      case (REG_ADDR)
        weigh_pkg::IDX_SCALE_CFG:
        begin
          cfg_next = weigh_pkg::scale_cfg_type'(REG_WDATA[17:0]);
          if (REG_WDATA[6:3] > 4'h9)
            cfg_next.filter = cfg_reg.filter;
        end
        weigh_pkg::IDX_PORT_CFG: port_next = weigh_pkg::port_cfg_type'(REG_WDATA[14:0]);
        weigh_pkg::IDX_CAL_ZERO: cal_zero_next = REG_WDATA[W-1:0];
        weigh_pkg::IDX_CAPACITY: cap_next = REG_WDATA[W-1:0];
        weigh_pkg::IDX_INTERVAL: intv_next = REG_WDATA[W-1:0];
        weigh_pkg::IDX_GAIN: gain_next = REG_WDATA[15:0];
        default: ;
      endcase
    end
    if (REG_RD)
    begin
      case (REG_ADDR)
        weigh_pkg::IDX_SCALE_CFG: rdata_next = 32'(cfg_reg);
        weigh_pkg::IDX_PORT_CFG: rdata_next = 32'(port_reg);
        weigh_pkg::IDX_CAL_ZERO: rdata_next = 32'(unsigned'(cal_zero_reg));
        weigh_pkg::IDX_CAPACITY: rdata_next = 32'(cap_reg);
        weigh_pkg::IDX_INTERVAL: rdata_next = 32'(intv_reg);
        weigh_pkg::IDX_GAIN: rdata_next = 32'(gain_reg);
        weigh_pkg::IDX_STATUS:
          rdata_next = {28'h0000000, phase_reg == ST_RUN, pz_hit_reg, net_reg, stable_reg};
        weigh_pkg::IDX_GROSS: rdata_next = 32'(signed'(gross));
        weigh_pkg::IDX_TARE: rdata_next = 32'(signed'(tare_reg));
        default: rdata_next = '0;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      cfg_reg <= weigh_pkg::SCALE_CFG_RST;
      port_reg <= weigh_pkg::PORT_CFG_RST;
      if (MODBUS_VARIANT)
        port_reg.format <= weigh_pkg::FMT_MODBUS;
      cal_zero_reg <= '0;
      cap_reg <= '0;
      intv_reg <= '0;
      gain_reg <= 16'h0000;
      rdata_reg <= '0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      port_reg <= port_next;
      cal_zero_reg <= cal_zero_next;
      cap_reg <= cap_next;
      intv_reg <= intv_next;
      gain_reg <= gain_next;
      rdata_reg <= rdata_next;
    end
  end

  // ***************************************************
  // Window decoding
  // ***************************************************

  // Percentages, counts and tenths per selection
  always_comb
  begin
    count_mode = cfg_reg.mode == weigh_pkg::MODE_COUNT;
    gross = (W+1)'(cur_reg) - (W+1)'(zero_reg);
    drift = (W+1)'(cur_reg) - (W+1)'(cal_zero_reg);
    step = (W+1)'(f_data) - (W+1)'(prev_reg);
    case (cfg_reg.zero_range)
      2'h1: zr_pct = 6'd2;
      2'h2: zr_pct = 6'd20;
      2'h3: zr_pct = 6'd40;
      default: zr_pct = 6'd0;
    endcase
    pz_pct = (cfg_reg.power_zero == 2'h1) ? 6'd2 : 6'd10;
    case (cfg_reg.motion)
      3'h1: {mcount, mtenths} = {9'd60, 5'd3};
      3'h2: {mcount, mtenths} = {9'd100, 5'd5};
      3'h3: {mcount, mtenths} = {9'd200, 5'd10};
      default: {mcount, mtenths} = {9'd400, 5'd20};
    endcase
    case (cfg_reg.auto_zero_follow)
      2'h1: atenths = 5'd5;
      2'h2: atenths = 5'd10;
      default: atenths = 5'd30;
    endcase
    if (cfg_reg.motion == 3'h0)
      motion_ok = 1'b1;
    else if (count_mode)
      motion_ok = mag(step) <= (W+1)'(mcount);
    else
      motion_ok = in_e(step, intv_reg, mtenths);
    range_ok = (zr_pct != 6'd0) && in_pct(drift, cap_reg, zr_pct);
  end

  // ***************************************************
  // Zero, tare and value path
  // ***************************************************

  // Next values of the processing state
  always_comb
  begin
    phase_next = phase_reg;
    prev_next = prev_reg;
    cur_next = cur_reg;
    zero_next = zero_reg;
    tare_next = tare_reg;
    net_next = net_reg;
    stable_next = stable_reg;
    pz_hit_next = pz_hit_reg;
    vvalid_next = 1'b0;
    value_next = value_reg;
    if (f_valid)
    begin
      prev_next = f_data;
      cur_next = f_data;
      stable_next = motion_ok;
    end
    case (phase_reg)
      ST_POWER_UP:
      begin
        zero_next = cal_zero_reg;
        if (f_valid)
        begin
          phase_next = ST_RUN;
          if (!count_mode && cfg_reg.power_zero != 2'h0 &&
              in_pct((W+1)'(f_data) - (W+1)'(cal_zero_reg), cap_reg, pz_pct))
          begin
            zero_next = f_data;
            pz_hit_next = 1'b1;
          end
          // restore tare, start in net mode
          if (!count_mode && cfg_reg.save_tare)
          begin
            tare_next = STORED_TARE;
            net_next = 1'b1;
          end
        end
      end
      ST_RUN:
      begin
        if (f_valid && !count_mode && cfg_reg.auto_zero_follow != 2'h0 && stable_reg &&
            range_ok && gross != '0 && in_e(gross, intv_reg, atenths))
          zero_next = cur_reg;
        // command zero needs stable and range
        if (ZERO_CMD && stable_reg && range_ok)
          zero_next = cur_reg;
        // tare needs positive gross, no motion
        if (TARE_CMD && cfg_reg.tare_en && !count_mode && stable_reg &&
            !gross[W] && gross != '0)
        begin
          tare_next = W'(gross);
          net_next = 1'b1;
        end
        vvalid_next = f_valid;
      end
      default: phase_next = ST_POWER_UP;
    endcase
    shown = net_reg ? gross - (W+1)'(tare_reg) : gross;
    scaled = (48'(shown) * 48'(signed'({1'b0, gain_reg}))) >>> weigh_pkg::GAIN_SHIFT;
    // ten times finer, never in count mode
    if (cfg_reg.hi_res)
      scaled = scaled * 48'(weigh_pkg::HIRES_FACTOR);
    if (f_valid)
      value_next = count_mode ? 32'(f_data) : scaled[31:0];
  end

  // Processing registers
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      phase_reg <= ST_POWER_UP;
      prev_reg <= '0;
      cur_reg <= '0;
      zero_reg <= '0;
      tare_reg <= '0;
      net_reg <= 1'b0;
      stable_reg <= 1'b0;
      pz_hit_reg <= 1'b0;
      vvalid_reg <= 1'b0;
      value_reg <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
      prev_reg <= prev_next;
      cur_reg <= cur_next;
      zero_reg <= zero_next;
      tare_reg <= tare_next;
      net_reg <= net_next;
      stable_reg <= stable_next;
      pz_hit_reg <= pz_hit_next;
      vvalid_reg <= vvalid_next;
      value_reg <= value_next;
    end
  end

  // ***************************************************
  // Serial port setup
  // ***************************************************

  // Effective port settings, recomputed every cycle
  always_comb
  begin
    // setup link overrides, saved format resumes
    fmt_next = SETUP_ACTIVE ? weigh_pkg::FMT_SETUP : port_reg.format;
    cks_next = port_reg.checksum_en && (port_reg.format == weigh_pkg::FMT_LEGACY);
    cr_next = port_reg.cr_en;
    lf_next = port_reg.lf_en;
    div_next = weigh_pkg::baud_div(port_reg.baud);
    frame_next = port_reg.framing;
    addr_next = port_reg.address;
    aen_next = port_reg.address != 5'h00;
    // Modbus forces 8N1 and a real address
    if (port_reg.format == weigh_pkg::FMT_MODBUS)
    begin
      frame_next = weigh_pkg::FRAME_8N1;
      if (port_reg.address == 5'h00)
        addr_next = weigh_pkg::ADDR_MIN;
      aen_next = 1'b1;
    end
  end

  // Port setting registers
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      fmt_reg <= weigh_pkg::FMT_OFF;
      cks_reg <= 1'b0;
      cr_reg <= 1'b0;
      lf_reg <= 1'b0;
      div_reg <= 16'h0000;
      frame_reg <= weigh_pkg::FRAME_8N1;
      addr_reg <= 5'h00;
      aen_reg <= 1'b0;
    end
    else
    begin
      fmt_reg <= fmt_next;
      cks_reg <= cks_next;
      cr_reg <= cr_next;
      lf_reg <= lf_next;
      div_reg <= div_next;
      frame_reg <= frame_next;
      addr_reg <= addr_next;
      aen_reg <= aen_next;
    end
  end

  // Outputs straight from flops
  assign REG_RDATA = rdata_reg;
  assign TARE_TO_STORE = tare_reg;
  assign VALUE_VALID = vvalid_reg;
  assign VALUE_DATA = value_reg;
  assign STABLE = stable_reg;
  assign NET_MODE = net_reg;
  assign PORT_FORMAT = fmt_reg;
  assign CHECKSUM_ON = cks_reg;
  assign CR_ON = cr_reg;
  assign LF_ON = lf_reg;
  assign BAUD_DIVISOR = div_reg;
  assign FRAMING = frame_reg;
  assign SLAVE_ADDR = addr_reg;
  assign ADDR_IN_FRAME = aen_reg;

endmodule
`default_nettype wire
